// ===== rtl/acsp_top.sv
// converter configuration serial port: link shifter, command decode, registers, straps
//
// Function
// - sample straps at reset in strap mode, float pins driven low
// - ignore strap changes after sampling
// - strap mode: defaults except clock, reference, common-mode
// - floating header: status, data, crc byte
// - mode pin high selects serial programming
// - mode 1: shift out rising, sample falling
// - decode last 16 or 24 bits only
// - chip select high resets link, tristates output
// - verify command crc over two bytes
// - read answered in the following frame
// - first byte: echo or read data
// - second byte status or zero, crc third
// - output crc over data and status
// - bad read address returns zero, flags when checking
// - bad write address always discarded, checking on or off
// - error: reject, invert echo, block writes
// - read crc error flags, reads still served
// - register map crc detects changes
// - chain: shifted input passes to output
// - sample mode pin at reset
// - status register writable while error set
`timescale 1ns/1ps
module acsp_top #(
  parameter int PULSE_CYC = acsp_pkg::STRAP_PULSE_CYC
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic link_sclk_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  input wire logic mode_pin_i,
  input wire logic [acsp_pkg::STRAP_PINS-1:0] strap_pin_i,
  output logic [acsp_pkg::STRAP_PINS-1:0] strap_pin_o,
  output logic [acsp_pkg::STRAP_PINS-1:0] strap_pin_oe_o,
  output logic serial_mode_o,
  output logic straps_valid_o,
  output logic [2*acsp_pkg::STRAP_PINS-1:0] strap_code_o,
  output logic ext_clock_o,
  output logic ref_high_o,
  output logic common_mode_output_en_o,
  output logic dp_status_en_o,
  output logic dp_crc_en_o,
  output logic [7:0] status_o
);

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] d);
    logic [7:0] c;
    c = crc ^ d;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ acsp_pkg::CRC8_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ acsp_pkg::CRC16_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [7:0] reg_reset(input int a);
    logic [7:0] v;
    v = 8'h00;
    if (a == int'(acsp_pkg::ADDR_DEV_ID)) begin
      v = acsp_pkg::DEV_ID_VAL;
    end else if (a == int'(acsp_pkg::ADDR_REV_ID)) begin
      v = acsp_pkg::REV_ID_VAL;
    end else if (a == int'(acsp_pkg::ADDR_STATUS)) begin
      v = acsp_pkg::RST_STATUS;
    end else if (a == int'(acsp_pkg::ADDR_GEN_CFG2)) begin
      v = acsp_pkg::RST_GEN_CFG2;
    end else if (a == int'(acsp_pkg::ADDR_IFACE_OPT)) begin
      v = acsp_pkg::RST_IFACE_OPT;
    end else if (a == int'(acsp_pkg::ADDR_DP_CFG1)) begin
      v = acsp_pkg::RST_DP_CFG1;
    end else if (a >= int'(acsp_pkg::ADDR_GAIN_MSB0)
                 && ((a - int'(acsp_pkg::ADDR_GAIN_MSB0)) % acsp_pkg::CH_STRIDE) == 0) begin
      v = acsp_pkg::RST_GAIN_MSB;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // link domain
  // ---------------------------------------------------------------
  // the response word and crc option are written only between frames, so
  // they stand still while the link clock runs and are read directly
  logic [23:0] resp;
  logic link_crc;
  logic link_rst;
  logic [23:0] shift_in;
  logic [4:0] fall_cnt;
  logic sdo_next;

  assign link_rst = cs_n_i | ~rstn_i;

  // the shifter keeps its contents when the frame ends so the other domain
  // can take it as the command word
  always_ff @(negedge link_sclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      shift_in <= 24'h000000;
    end else if (!cs_n_i) begin
      if (fall_cnt == 5'h00) begin
        shift_in <= {resp[22:0], sdi_i};
      end else begin
        shift_in <= {shift_in[22:0], sdi_i};
      end
    end
  end

  always_ff @(negedge link_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      fall_cnt <= 5'h00;
    end else if (fall_cnt != 5'h1f) begin
      fall_cnt <= fall_cnt + 5'h01;
    end
  end

  always_comb begin
    if (fall_cnt == 5'h00) begin
      sdo_next = link_crc ? resp[23] : resp[15];
    end else begin
      sdo_next = link_crc ? shift_in[23] : shift_in[15];
    end
  end

  always_ff @(posedge link_sclk_i or posedge link_rst) begin
    if (link_rst) begin
      sdo_o <= 1'b0;
      sdo_oe_o <= 1'b0;
    end else begin
      sdo_o <= sdo_next;
      sdo_oe_o <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] cs_sync;
  logic cs_prev;
  logic [1:0] mode_sync;
  logic [acsp_pkg::STRAP_PINS-1:0] strap_s1;
  logic [acsp_pkg::STRAP_PINS-1:0] strap_s2;
  logic frame_end;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_sync <= 2'h3;
      cs_prev <= 1'b1;
      mode_sync <= 2'h0;
      strap_s1 <= '0;
      strap_s2 <= '0;
    end else begin
      cs_sync <= {cs_sync[0], cs_n_i};
      cs_prev <= cs_sync[1];
      mode_sync <= {mode_sync[0], mode_pin_i};
      strap_s1 <= strap_pin_i;
      strap_s2 <= strap_s1;
    end
  end

  assign frame_end = cs_sync[1] & ~cs_prev;

  // ---------------------------------------------------------------
  // strap sampling
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {ACSP_ST_START, ACSP_ST_HIGH, ACSP_ST_LOW, ACSP_ST_DONE} acsp_strap_t;
  acsp_strap_t strap_st;
  logic [15:0] pulse_cnt;
  logic [acsp_pkg::STRAP_PINS-1:0] seen_high;
  logic pulse_end;

  // PULSE_CYC must be at least 3: the pin synchroniser needs two cycles to settle
  assign pulse_end = (pulse_cnt == 16'(PULSE_CYC - 1));

  // straps are read once after reset and then held until the next reset
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_st <= ACSP_ST_START;
      pulse_cnt <= 16'h0000;
      serial_mode_o <= 1'b0;
      straps_valid_o <= 1'b0;
      seen_high <= '0;
      strap_code_o <= '0;
      strap_pin_o <= '0;
      strap_pin_oe_o <= '0;
    end else begin
      pulse_cnt <= pulse_end ? 16'h0000 : pulse_cnt + 16'h0001;
      case (strap_st)
        ACSP_ST_START: begin
          if (pulse_end) begin
            serial_mode_o <= mode_sync[1];
            if (mode_sync[1]) begin
              strap_st <= ACSP_ST_DONE;
              straps_valid_o <= 1'b1;
            end else begin
              strap_st <= ACSP_ST_HIGH;
              strap_pin_o <= '1;
              strap_pin_oe_o <= '1;
            end
          end
        end
        ACSP_ST_HIGH: begin
          if (pulse_end) begin
            seen_high <= strap_s2;
            strap_pin_o <= '0;
            strap_st <= ACSP_ST_LOW;
          end
        end
        ACSP_ST_LOW: begin
          if (pulse_end) begin
            for (int i = 0; i < acsp_pkg::STRAP_PINS; i++) begin
              if (seen_high[i] && !strap_s2[i]) begin
                strap_code_o[2*i +: 2] <= acsp_pkg::STRAP_FLOAT;
              end else begin
                strap_code_o[2*i +: 2] <= strap_s2[i] ? acsp_pkg::STRAP_HIGH
                                                       : acsp_pkg::STRAP_LOW;
              end
            end
            // a pin that followed both pulses is floating and stays driven low
            strap_pin_oe_o <= seen_high & ~strap_s2;
            strap_st <= ACSP_ST_DONE;
          end
        end
        ACSP_ST_DONE: begin
          // valid one cycle after the code so the derived options have settled
          straps_valid_o <= 1'b1;
          strap_st <= ACSP_ST_DONE;
        end
        default: begin
          strap_st <= ACSP_ST_START;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // register file and command decode
  // ---------------------------------------------------------------
  logic [7:0] regs [0:acsp_pkg::NUM_REGS-1];
  logic [7:0] b1, b2, bcrc;
  logic [6:0] addr;
  logic crc_on, crc_err, addr_bad, addr_err, is_write, wr_blocked, do_write;
  logic [7:0] iopt, status, next_status, rd_data;
  logic [7:0] st_set, st_clr;
  logic [7:0] first_byte;
  logic resp_pend;
  logic reg_err_set;

  assign iopt = regs[acsp_pkg::ADDR_IFACE_OPT];
  assign status = regs[acsp_pkg::ADDR_STATUS];
  assign crc_on = iopt[acsp_pkg::IO_CRC_EN];

  always_comb begin
    if (crc_on) begin
      b1 = shift_in[23:16];
      b2 = shift_in[15:8];
      bcrc = shift_in[7:0];
    end else begin
      b1 = shift_in[15:8];
      b2 = shift_in[7:0];
      bcrc = 8'h00;
    end
    addr = b1[6:0];
    is_write = b1[acsp_pkg::CMD_WRITE_BIT];
    crc_err = crc_on && (crc8_byte(crc8_byte(acsp_pkg::CRC8_INIT, b1), b2) != bcrc);
    addr_bad = addr > acsp_pkg::ADDR_LAST;
    addr_err = addr_bad && iopt[acsp_pkg::IO_ADDR_EN];
    wr_blocked = crc_err || addr_err || addr < acsp_pkg::ADDR_FIRST_WR
                 || (status[acsp_pkg::ST_SPI_ERR] && addr != acsp_pkg::ADDR_STATUS);
    do_write = frame_end && is_write && !wr_blocked && !addr_bad;
    rd_data = addr_bad ? 8'h00 : regs[addr];
    st_set = 8'h00;
    st_clr = 8'h00;
    if (frame_end) begin
      st_set[acsp_pkg::ST_SPI_ERR] = crc_err || (is_write && addr_err);
      st_set[acsp_pkg::ST_ADDR_ERR] = addr_err;
    end
    st_set[acsp_pkg::ST_REG_ERR] = reg_err_set;
    if (do_write && addr == acsp_pkg::ADDR_STATUS) begin
      st_clr = b2 & acsp_pkg::ST_W1C_MASK;
    end
    next_status = (status & ~st_clr) | st_set; // set wins over clear
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < acsp_pkg::NUM_REGS; i++) begin
        regs[i] <= reg_reset(i);
      end
    end else begin
      if (do_write && addr != acsp_pkg::ADDR_STATUS) begin
        regs[addr] <= b2;
      end
      regs[acsp_pkg::ADDR_STATUS] <= next_status;
    end
  end

  // answer is prepared after the frame closes and sent in the next frame
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      first_byte <= 8'h00;
      resp_pend <= 1'b0;
      resp <= 24'h000000;
      link_crc <= 1'b0;
    end else begin
      resp_pend <= frame_end;
      if (frame_end) begin
        if (is_write) begin
          first_byte <= (wr_blocked || addr_bad) ? ~b2 : b2;
        end else begin
          first_byte <= rd_data;
        end
      end
      if (resp_pend) begin
        link_crc <= crc_on;
        if (crc_on) begin
          resp <= {first_byte, iopt[acsp_pkg::IO_STAT_EN] ? status : 8'h00,
                   crc8_byte(crc8_byte(acsp_pkg::CRC8_INIT, first_byte),
                             iopt[acsp_pkg::IO_STAT_EN] ? status : 8'h00)};
        end else begin
          resp <= {8'h00, first_byte, iopt[acsp_pkg::IO_STAT_EN] ? status : 8'h00};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // register map crc scanner
  // ---------------------------------------------------------------
  // one address per cycle; a change is seen within two passes of the map
  logic [6:0] scan_addr;
  logic [15:0] scan_crc;

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scan_addr <= acsp_pkg::ADDR_MAPCRC_FIRST;
      scan_crc <= acsp_pkg::CRC16_INIT;
      reg_err_set <= 1'b0;
    end else begin
      reg_err_set <= 1'b0;
      if (scan_addr == acsp_pkg::ADDR_LAST) begin
        scan_addr <= acsp_pkg::ADDR_MAPCRC_FIRST;
        scan_crc <= acsp_pkg::CRC16_INIT;
        reg_err_set <= iopt[acsp_pkg::IO_REGCRC_EN] &&
                       crc16_byte(scan_crc, regs[scan_addr]) !=
                       {regs[acsp_pkg::ADDR_CRC_MSB], regs[acsp_pkg::ADDR_CRC_LSB]};
      end else begin
        scan_addr <= scan_addr + 7'h01;
        scan_crc <= crc16_byte(scan_crc, regs[scan_addr]);
      end
    end
  end

  // ---------------------------------------------------------------
  // configuration outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_clock_o <= 1'b0;
      ref_high_o <= 1'b0;
      common_mode_output_en_o <= 1'b0;
      dp_status_en_o <= 1'b0;
      dp_crc_en_o <= 1'b0;
      status_o <= acsp_pkg::RST_STATUS;
    end else begin
      status_o <= next_status;
      if (serial_mode_o) begin
        ext_clock_o <= regs[acsp_pkg::ADDR_CLK_CFG][acsp_pkg::CK_CLK_SEL];
        ref_high_o <= regs[acsp_pkg::ADDR_GEN_CFG1][acsp_pkg::G1_REF_RNG];
        common_mode_output_en_o <= regs[acsp_pkg::ADDR_GEN_CFG1][acsp_pkg::G1_VCM];
        dp_status_en_o <= regs[acsp_pkg::ADDR_DP_CFG1][acsp_pkg::DP_STAT_EN];
        dp_crc_en_o <= regs[acsp_pkg::ADDR_DP_CFG1][acsp_pkg::DP_CRC_EN];
      end else begin
        ext_clock_o <= 1'b1;
        ref_high_o <= 1'b1;
        common_mode_output_en_o <= 1'b1;
        dp_status_en_o <= strap_code_o[2*acsp_pkg::STRAP_HDR +: 2] != acsp_pkg::STRAP_LOW;
        dp_crc_en_o <= strap_code_o[2*acsp_pkg::STRAP_HDR +: 2] == acsp_pkg::STRAP_FLOAT;
      end
    end
  end

endmodule

// ===== rtl/acsp_pkg.sv
// constants for the converter configuration serial port
package acsp_pkg;
  // register map
  localparam logic [6:0] ADDR_STATUS = 7'h02;
  localparam logic [6:0] ADDR_CRC_MSB = 7'h05;
  localparam logic [6:0] ADDR_CRC_LSB = 7'h06;
  localparam logic [6:0] ADDR_GEN_CFG1 = 7'h08;
  localparam logic [6:0] ADDR_IFACE_OPT = 7'h0a;
  localparam logic [6:0] ADDR_DP_CFG1 = 7'h0b;
  localparam logic [6:0] ADDR_CLK_CFG = 7'h0d;
  localparam logic [6:0] ADDR_FIRST_WR = 7'h02;
  localparam logic [6:0] ADDR_LAST = 7'h50;
  localparam logic [6:0] ADDR_MAPCRC_FIRST = 7'h08;
  localparam logic [6:0] ADDR_DEV_ID = 7'h00;
  localparam logic [6:0] ADDR_REV_ID = 7'h01;
  localparam logic [6:0] ADDR_GEN_CFG2 = 7'h09;
  localparam logic [6:0] ADDR_GAIN_MSB0 = 7'h16;
  localparam int CH_STRIDE = 8;
  localparam int NUM_REGS = 81;
  // reset values
  localparam logic [7:0] RST_STATUS = 8'h60;
  localparam logic [7:0] RST_GEN_CFG2 = 8'h04;
  localparam logic [7:0] RST_IFACE_OPT = 8'hc0;
  localparam logic [7:0] RST_DP_CFG1 = 8'h20;
  localparam logic [7:0] RST_GAIN_MSB = 8'h40;
  // status bits
  localparam int ST_SPI_ERR = 4;
  localparam int ST_REG_ERR = 3;
  localparam int ST_ADDR_ERR = 1;
  localparam logic [7:0] ST_W1C_MASK = 8'h7b;
  // interface options bits
  localparam int IO_STAT_EN = 4;
  localparam int IO_ADDR_EN = 3;
  localparam int IO_CRC_EN = 1;
  localparam int IO_REGCRC_EN = 0;
  // other config bits
  localparam int DP_CRC_EN = 7;
  localparam int DP_STAT_EN = 6;
  localparam int G1_VCM = 2;
  localparam int G1_REF_RNG = 0;
  localparam int CK_CLK_SEL = 3;
  // command byte
  localparam int CMD_WRITE_BIT = 7;
  // frame lengths
  localparam int FRAME_BITS = 16;
  localparam int FRAME_BITS_CRC = 24;
  // crc
  localparam logic [7:0] CRC8_POLY = 8'h07;
  localparam logic [7:0] CRC8_INIT = 8'hff;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [15:0] CRC16_INIT = 16'hffff;
  // strap codes
  localparam logic [1:0] STRAP_LOW = 2'h0;
  localparam logic [1:0] STRAP_HIGH = 2'h1;
  localparam logic [1:0] STRAP_FLOAT = 2'h2;
  localparam int STRAP_PINS = 6;
  localparam int STRAP_HDR = 5;
  // timing
  localparam int CLK_MHZ = 20;
  localparam int STRAP_PULSE_NS = 2000;
  localparam int STRAP_PULSE_CYC = (STRAP_PULSE_NS * CLK_MHZ + 999) / 1000;
  // arbitrary identification values
  localparam logic [7:0] DEV_ID_VAL = 8'h5a;
  localparam logic [7:0] REV_ID_VAL = 8'h01;
endpackage

// ===== sim/acsp_host_model.sv
// host controller model driving the serial configuration link
`timescale 1ns/1ps
module acsp_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic sdi_o,
  input wire logic sdo_i,
  input wire logic sdo_oe_i
);
  localparam int HALF_NS = 80;
  logic line;
  // released line reads the inverse, so a stale bit never passes as data
  assign line = sdo_oe_i ? sdo_i : ~sdo_i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // clock stands low between frames; gap covers the decode time
  task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
    rx = '0;
    #37;
    cs_n_o = 1'b0;
    #HALF_NS;
    for (int i = n - 1; i >= 0; i--) begin
      sclk_o = 1'b1;
      sdi_o = tx[i];
      #HALF_NS;
      sclk_o = 1'b0;
      rx[i] = line;
      #HALF_NS;
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #1000;
  endtask
endmodule

// ===== sim/acsp_top_checker.sv
// concurrent checks on the configuration port pins
`timescale 1ns/1ps
module acsp_top_checker #(
  parameter int PULSE_CYC = 2
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic link_sclk_i,
  input wire logic cs_n_i,
  input wire logic sdo_oe_o,
  input wire logic mode_pin_i,
  input wire logic [acsp_pkg::STRAP_PINS-1:0] strap_pin_o,
  input wire logic [acsp_pkg::STRAP_PINS-1:0] strap_pin_oe_o,
  input wire logic serial_mode_o,
  input wire logic straps_valid_o,
  input wire logic [2*acsp_pkg::STRAP_PINS-1:0] strap_code_o,
  input wire logic ext_clock_o,
  input wire logic ref_high_o,
  input wire logic common_mode_output_en_o,
  input wire logic dp_status_en_o,
  input wire logic dp_crc_en_o,
  input wire logic [7:0] status_o
);
  logic [acsp_pkg::STRAP_PINS-1:0] flt;
  logic [7:0] cnt;
  logic hw;
  assign hw = straps_valid_o && !serial_mode_o;
  always_comb begin
    for (int k = 0; k < acsp_pkg::STRAP_PINS; k++) begin
      flt[k] = strap_code_o[2*k+:2] == acsp_pkg::STRAP_FLOAT;
    end
  end
  // saturating count of cycles since reset release
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end
  AST_OE_OFF: assert property (@(posedge clock_i) disable iff (!rstn_i)
    cs_n_i |-> !sdo_oe_o) else $error("sdo driven while deselected");
  AST_OE_FRAME: assert property (@(negedge link_sclk_i) disable iff (cs_n_i)
    sdo_oe_o) else $error("sdo not driven at sampling edge");
  AST_STRAP_HOLD: assert property (@(posedge clock_i) disable iff (!rstn_i)
    straps_valid_o && $past(straps_valid_o) |-> $stable(strap_code_o))
    else $error("strap code changed after sampling");
  AST_FLOAT_LOW: assert property (@(posedge clock_i) disable iff (!rstn_i)
    hw |-> (flt & ~(strap_pin_oe_o & ~strap_pin_o)) == '0)
    else $error("floating strap not driven low");
  AST_HW_DEFAULTS: assert property (@(posedge clock_i) disable iff (!rstn_i)
    hw |-> ext_clock_o && ref_high_o && common_mode_output_en_o)
    else $error("strap mode defaults wrong");
  AST_HDR_FLOAT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    hw && flt[acsp_pkg::STRAP_HDR] |-> dp_status_en_o && dp_crc_en_o)
    else $error("header strap float options wrong");
  AST_MODE_SEL: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $rose(straps_valid_o) |-> serial_mode_o == mode_pin_i)
    else $error("programming mode not taken from mode pin");
  AST_STRAP_WAIT: assert property (@(posedge clock_i) disable iff (!rstn_i)
    straps_valid_o |-> cnt >= PULSE_CYC) else $error("straps valid too early");
  AST_ERR_CLR: assert property (@(posedge clock_i) disable iff (!rstn_i)
    $fell(status_o[acsp_pkg::ST_SPI_ERR]) |-> cs_n_i && $past(cs_n_i, 2))
    else $error("serial error cleared inside a frame");
endmodule
bind acsp_top acsp_top_checker #(.PULSE_CYC(PULSE_CYC)) u_chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .link_sclk_i(link_sclk_i), .cs_n_i(cs_n_i),
  .sdo_oe_o(sdo_oe_o), .mode_pin_i(mode_pin_i), .strap_pin_o(strap_pin_o),
  .strap_pin_oe_o(strap_pin_oe_o), .serial_mode_o(serial_mode_o),
  .straps_valid_o(straps_valid_o), .strap_code_o(strap_code_o), .ext_clock_o(ext_clock_o),
  .ref_high_o(ref_high_o), .common_mode_output_en_o(common_mode_output_en_o),
  .dp_status_en_o(dp_status_en_o), .dp_crc_en_o(dp_crc_en_o), .status_o(status_o));

// ===== sim/adc_config_serial_port_tb.sv
// self-checking bench for the configuration serial port
`timescale 1ns/1ps
module adc_config_serial_port_tb;
  logic clock_i, rstn_i, sclk, cs_n, sdi, sdo_o, sdo_oe_o, mode_pin_i;
  logic serial_mode_o, straps_valid_o, ext_clock_o, ref_high_o, cm_en, dp_st, dp_crc;
  logic [5:0] lv, fl, pin_i, pin_o, pin_oe;
  logic [11:0] code, exp_code;
  logic [7:0] status_o;
  logic [31:0] rx;
  int n_fail = 0;
  int checks_done = 0;
  int cyc = 0;
  // weak strap driver wins only over a floating pin
  always_comb begin
    for (int k = 0; k < 6; k++) begin
      pin_i[k] = fl[k] ? (pin_oe[k] ? pin_o[k] : ~pin_o[k]) : lv[k];
    end
  end
  acsp_top #(.PULSE_CYC(4)) uut (
    .clock_i(clock_i), .rstn_i(rstn_i), .link_sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .mode_pin_i(mode_pin_i), .strap_pin_i(pin_i),
    .strap_pin_o(pin_o), .strap_pin_oe_o(pin_oe), .serial_mode_o(serial_mode_o),
    .straps_valid_o(straps_valid_o), .strap_code_o(code), .ext_clock_o(ext_clock_o),
    .ref_high_o(ref_high_o), .common_mode_output_en_o(cm_en), .dp_status_en_o(dp_st),
    .dp_crc_en_o(dp_crc), .status_o(status_o));
  acsp_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_i(sdo_o),
    .sdo_oe_i(sdo_oe_o));
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'hff;
    for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction
  task automatic do_reset(input logic m);
    @(negedge clock_i);
    mode_pin_i = m;
    rstn_i = 1'b0;
    repeat (3) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (30) @(negedge clock_i);
  endtask
  task automatic fr(input logic [31:0] tx, input int n);
    host.xfer(tx, n, rx);
  endtask
  //----------------------------------------
  // strap mode
  //----------------------------------------
  task automatic test_strap();
    lv = 6'h05;
    fl = 6'h24;
    do_reset(1'b0);
    for (int k = 0; k < 6; k++) exp_code[2*k+:2] = fl[k] ? 2'h2 : {1'b0, lv[k]};
    chk(code, exp_code);
    chk(pin_oe & fl, fl);
    chk(pin_o & fl, 6'h00);
    chk(serial_mode_o, 1'b0);
    chk({ext_clock_o, ref_high_o, cm_en}, 3'h7);
    chk({dp_st, dp_crc}, 2'h3);
    @(negedge clock_i);
    lv = 6'h1a;
    repeat (10) @(negedge clock_i);
    chk(code, exp_code);
    $display("test strap done");
  endtask
  //----------------------------------------
  // serial frames, chain, errors, crc
  //----------------------------------------
  task automatic test_serial();
    do_reset(1'b1);
    chk(serial_mode_o, 1'b1);
    chk(status_o, 8'h60);
    fr(32'h1234_8bc0, 32);
    chk(rx, 32'h0000_1234);
    chk({dp_crc, dp_st}, 2'h3);
    fr(32'h0b00, 16);
    chk(rx[15:0], 16'hc000);
    fr(32'h00, 8);
    chk(rx[7:0], 8'hc0);
    fr(32'h8ad8, 16);
    fr(32'h6000, 16);
    fr(32'h0200, 16);
    chk(rx[15:8], 8'h00);
    fr(32'he055, 16);
    chk(rx[15:0], 16'h6262);
    chk(status_o, 8'h72);
    fr(32'h8b00, 16);
    chk(rx[15:8], 8'haa);
    fr(32'h8212, 16);
    chk(rx[15:8], 8'hff);
    chk(status_o, 8'h60);
    chk(dp_crc, 1'b1);
    $display("test serial done");
  endtask
  task automatic test_crc();
    fr(32'h8ada, 16);
    fr(32'h0b0000, 24);
    chk(status_o, 8'h70);
    fr({8'h00, 16'h0b00, crc8(16'h0b00)}, 24);
    fr({8'h00, 16'h0000, crc8(16'h0000)}, 24);
    chk(rx[23:8], 16'hc070);
    chk(rx[7:0], crc8(16'hc070));
    $display("test crc done");
  endtask
  task automatic test_map_crc();
    fr({8'h00, 16'h8210, crc8(16'h8210)}, 24);
    chk(status_o, 8'h60);
    fr({8'h00, 16'h8adb, crc8(16'h8adb)}, 24);
    repeat (200) @(negedge clock_i);
    chk(status_o, 8'h68);
    $display("test map crc done");
  endtask
  task automatic finish_test();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    rstn_i = 1'b0;
    mode_pin_i = 1'b0;
    lv = 6'h00;
    fl = 6'h00;
    test_strap();
    test_serial();
    test_crc();
    test_map_crc();
    finish_test();
  end
endmodule
